// ### core/fps_sequencer.v
/*
  front panel parameter entry and persistent switch sequencer.
  holds numeric, knob and picklist entry state, applies values to the
  parameter setpoint and sequences the switch heater with timed holds.
  assumes one ahb-lite master, keys delivered as register writes, and
  an external ramp engine that reports when it reached its target.
*/
// Chosen here: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`include "fps_defs.vh"

module fps_sequencer #(
  parameter TICK_CYCLES = `FPS_CLK_HZ,  // cycles per second tick
  parameter VAL_W       = 16,          // parameter value width
  parameter PICK_W      = 3            // picklist index width
) (
  input  wire              clk,
  input  wire              rst_b,
  input  wire              hsel,
  input  wire [31:0]       haddr,
  input  wire [1:0]        htrans,
  input  wire              hwrite,
  input  wire [2:0]        hsize,
  input  wire [31:0]       hwdata,
  input  wire              hready,
  output wire              hreadyout,
  output wire              hresp,
  output reg  [31:0]       hrdata,
  input  wire              ramp_done,
  output reg  [VAL_W-1:0]  supply_setpoint,
  output reg               heater_on,
  output reg               beep,
  output reg               comp_enable,
  output reg  [VAL_W-1:0]  loop_gain_add,
  output reg               to_parent
);

  // ****************************************************************
  // constants
  // ****************************************************************
  localparam [1:0] SW_IDLE = 2'h0;  // no transition
  localparam [1:0] SW_COOL = 2'h1;  // heater off, holding current
  localparam [1:0] SW_RAMP = 2'h2;  // supply ramping via ramp engine
  localparam [1:0] SW_HEAT = 2'h3;  // heater on, compensation delayed

  // ****************************************************************
  // state
  // ****************************************************************
  reg              wr_pend;        // data phase of a write pending
  reg  [7:0]       wr_addr;        // latched write offset
  reg  [31:0]      tick_cnt;       // divider for the second tick
  reg              sec_tick;       // one-cycle second pulse
  reg  [7:0]       ctrl;           // item and switch configuration
  reg  [VAL_W-1:0] entry_buf;      // digits being typed
  reg              entry_active;   // numeric entry in progress
  reg              has_digits;     // digits present in buffer
  reg              knob_live;      // knob adjusting the setpoint
  reg              pick_active;    // list entry in progress
  reg              shift;          // shift pressed, awaiting key
  reg  [VAL_W-1:0] param_val;      // accepted parameter value
  reg  [VAL_W-1:0] saved_val;      // value to restore on escape
  reg  [VAL_W-1:0] lim_lo;         // parameter valid minimum
  reg  [VAL_W-1:0] lim_hi;         // parameter valid maximum
  reg  [PICK_W-1:0] pick_sel;      // selector position
  reg  [PICK_W-1:0] pick_val;      // applied choice
  reg  [PICK_W-1:0] pick_last;     // index of the last choice
  reg  [11:0]      heat_time;      // heated hold seconds
  reg  [11:0]      cool_time;      // cooled hold seconds
  reg              heat_set;       // heated time written
  reg              cool_set;       // cooled time written
  reg  [VAL_W-1:0] ps_rate;        // switch supply ramp rate
  reg  [VAL_W-1:0] cool_gain;      // cooling gain percent
  reg  [VAL_W-1:0] magnet_i;       // magnet current at cooling
  reg  [1:0]       sw_state;       // switch sequencer state
  reg  [11:0]      hold_cnt;       // seconds elapsed in hold
  reg  [7:0]       knob_gap;       // prescaler wraps since last knob move
  reg  [9:0]       knob_div;       // prescaler for the knob gap count
  reg              ramp_zero;      // ramp target is zero
  wire [1:0]       item_kind;      // which rate this item edits
  wire             sw_busy;        // cooling hold or heating hold before compensation
  wire             sw_ready;       // switch configured fully
  wire             knob_allowed;   // knob permitted on this item
  wire             wr_go;          // write data phase now
  wire [3:0]       key;            // key code from data
  wire [15:0]      kdata;          // key payload

  assign hreadyout = 1'b1;  // zero wait states
  assign hresp     = 1'b0;  // always okay
  assign wr_go     = wr_pend;
  assign key       = hwdata[19:16];
  assign kdata     = hwdata[15:0];
  assign item_kind = ctrl[`FPS_CTRL_ITEM_LO+1:`FPS_CTRL_ITEM_LO];
  assign sw_busy   = (sw_state == SW_COOL) || (sw_state == SW_HEAT && !comp_enable);
  assign sw_ready  = ctrl[`FPS_CTRL_SW_INST] && ctrl[`FPS_CTRL_HCUR_SET]
                     && heat_set && cool_set;
  // rate only when no switch or fully heated; psrate only fully cooled
  assign knob_allowed = ctrl[`FPS_CTRL_KNOB_OK] && !sw_busy &&
    ((item_kind == `FPS_ITEM_RATE)   ? (!ctrl[`FPS_CTRL_SW_INST] || heater_on) :
     (item_kind == `FPS_ITEM_PSRATE) ? (ctrl[`FPS_CTRL_SW_INST] && !heater_on) :
     1'b1);

  // ****************************************************************
  // second tick divider
  // ****************************************************************
  // a long count, so the divider width is generous and simulation may
  // shorten it with TICK_CYCLES
  always @(posedge clk) begin
    if (!rst_b) begin
      tick_cnt <= 32'h00000000;
      sec_tick <= 1'b0;
    end else if (tick_cnt >= TICK_CYCLES - 1) begin
      tick_cnt <= 32'h00000000;
      sec_tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h00000001;
      sec_tick <= 1'b0;
    end
  end

  // ****************************************************************
  // ahb-lite address phase capture
  // ****************************************************************
  always @(posedge clk) begin
    if (!rst_b) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else if (hready) begin
      wr_pend <= hsel && htrans[1] && hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  // read data registered at the address phase; unmapped reads zero
  always @(posedge clk) begin
    if (!rst_b) begin
      hrdata <= 32'h00000000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr[7:0])
        `FPS_OFF_CTRL:   hrdata <= {24'h000000, ctrl};
        `FPS_OFF_ENTRY:  hrdata <= {16'h0000, entry_buf};
        `FPS_OFF_STATUS: hrdata <= {20'h00000, has_digits, comp_enable, sw_state,
                                    heater_on, shift, pick_active, knob_live,
                                    entry_active, 3'h0};
        `FPS_OFF_SETPT:  hrdata <= {16'h0000, param_val};
        `FPS_OFF_LIMITS: hrdata <= {lim_hi, lim_lo};
        `FPS_OFF_PICK:   hrdata <= {21'h000000, pick_last, 2'h0, pick_val, pick_sel};
        `FPS_OFF_HEATT:  hrdata <= {20'h00000, heat_time};
        `FPS_OFF_COOLT:  hrdata <= {20'h00000, cool_time};
        `FPS_OFF_PSRATE: hrdata <= {16'h0000, ps_rate};
        `FPS_OFF_MAGI:   hrdata <= {16'h0000, magnet_i};
        `FPS_OFF_GAIN:   hrdata <= {16'h0000, cool_gain};
        default:         hrdata <= 32'h00000000;
      endcase
    end
  end

  // ****************************************************************
  // entry, knob, picklist and switch sequencing
  // ****************************************************************
  always @(posedge clk) begin
    if (!rst_b) begin
      ctrl         <= 8'h00;
      entry_buf    <= {VAL_W{1'b0}};
      entry_active <= 1'b0;
      has_digits   <= 1'b0;
      knob_live    <= 1'b0;
      pick_active  <= 1'b0;
      shift        <= 1'b0;
      param_val    <= {VAL_W{1'b0}};
      saved_val    <= {VAL_W{1'b0}};
      lim_lo       <= {VAL_W{1'b0}};
      lim_hi       <= {VAL_W{1'b1}};
      pick_sel     <= {PICK_W{1'b0}};
      pick_val     <= {PICK_W{1'b0}};
      pick_last    <= {PICK_W{1'b1}};
      heat_time    <= `FPS_HEAT_DEF;
      cool_time    <= `FPS_COOL_DEF;
      heat_set     <= 1'b0;
      cool_set     <= 1'b0;
      ps_rate      <= `FPS_PSRATE_DEF;
      cool_gain    <= `FPS_GAIN_DEF;
      magnet_i     <= {VAL_W{1'b0}};
      sw_state     <= SW_IDLE;
      hold_cnt     <= 12'h000;
      heater_on    <= 1'b0;
      comp_enable  <= 1'b0;
      ramp_zero    <= 1'b0;
      supply_setpoint <= {VAL_W{1'b0}};
      knob_gap     <= 8'h00;
      knob_div     <= 10'h000;
      beep         <= 1'b0;
      to_parent    <= 1'b0;
    end else begin
      beep      <= 1'b0;
      to_parent <= 1'b0;
      // velocity estimate: gap since last knob move saturates
      // own prescaler, so the gap keeps counting whatever the tick length
      knob_div <= knob_div + 10'h001;
      if (knob_div == 10'h3FF && knob_gap != 8'hFF) begin
        knob_gap <= knob_gap + 8'h01;
      end
      // ---------------- switch sequencer, hold timing in seconds
      case (sw_state)
        SW_COOL: begin
          if (sec_tick) begin
            hold_cnt <= hold_cnt + 12'h001;
          end
          // one tick beyond the count: the first tick may fall at once
          if (sec_tick && hold_cnt >= cool_time) begin
            ramp_zero       <= 1'b1;
            supply_setpoint <= {VAL_W{1'b0}};
            sw_state        <= SW_RAMP;
          end
        end
        SW_RAMP: begin
          // ramp engine moves toward supply_setpoint; ps_rate is not driven to it
          if (ramp_done) begin
            if (!ramp_zero) begin
              heater_on <= 1'b1;
              hold_cnt  <= 12'h000;
              sw_state  <= SW_HEAT;
            end else begin
              sw_state  <= SW_IDLE;
            end
          end
        end
        SW_HEAT: begin
          if (sec_tick) begin
            hold_cnt <= hold_cnt + 12'h001;
          end
          // one tick beyond the count, so the full heated time has passed
          if (sec_tick && hold_cnt >= heat_time) begin
            comp_enable <= 1'b1;
            sw_state    <= SW_IDLE;
          end
        end
        SW_IDLE: begin
          hold_cnt <= 12'h000;
        end
        default: begin
          sw_state <= SW_IDLE;
        end
      endcase
      // ---------------- register writes
      if (wr_go) begin
        case (wr_addr)
          `FPS_OFF_CTRL:   ctrl <= hwdata[7:0];
          `FPS_OFF_LIMITS: begin
            lim_lo <= hwdata[15:0];
            lim_hi <= hwdata[31:16];
          end
          `FPS_OFF_PICK:   pick_last <= hwdata[8+PICK_W-1:8];
          `FPS_OFF_HEATT:  begin
            if (hwdata[11:0] >= `FPS_HEAT_MIN && hwdata[11:0] <= `FPS_HEAT_MAX) begin
              heat_time <= hwdata[11:0];
              heat_set  <= 1'b1;
            end else begin
              beep <= 1'b1;
            end
          end
          `FPS_OFF_COOLT:  begin
            if (hwdata[11:0] >= `FPS_COOL_MIN && hwdata[11:0] <= `FPS_COOL_MAX) begin
              cool_time <= hwdata[11:0];
              cool_set  <= 1'b1;
            end else begin
              beep <= 1'b1;
            end
          end
          `FPS_OFF_PSRATE: ps_rate   <= hwdata[15:0];
          `FPS_OFF_GAIN:   cool_gain <= hwdata[15:0];
          `FPS_OFF_MAGI:   magnet_i  <= hwdata[15:0];  // preset recorded current
          `FPS_OFF_KNOB: begin
            if (knob_live) begin
              // faster turning gives a coarser step; slow gives sub-digit
              if (knob_gap < 8'h04) begin
                param_val <= hwdata[0] ? param_val - 16'h0064 : param_val + 16'h0064;
              end else if (knob_gap < 8'h20) begin
                param_val <= hwdata[0] ? param_val - 16'h000A : param_val + 16'h000A;
              end else begin
                param_val <= hwdata[0] ? param_val - 16'h0001 : param_val + 16'h0001;
              end
              knob_gap <= 8'h00;
            end
          end
          `FPS_OFF_KEY: begin
            if (knob_live) begin
              knob_live <= 1'b0;
              if (key != `FPS_KEY_ENTER) begin
                param_val <= saved_val;
              end
            end else if (shift) begin
              shift <= 1'b0;
              if (key == `FPS_KEY_KNOB) begin
                if (knob_allowed) begin
                  knob_live <= 1'b1;
                  saved_val <= param_val;
                end else begin
                  beep <= 1'b1;
                end
              end else if (key == `FPS_KEY_SWITCH) begin
                if (!sw_ready) begin
                  beep <= 1'b1;
                end else begin
                  heater_on   <= !heater_on;
                  comp_enable <= 1'b0;  // compensation waits for a full heating
                end
              end
            end else if (pick_active) begin
              if (key == `FPS_KEY_ENTER) begin
                pick_val    <= pick_sel;
                pick_active <= 1'b0;
              end else if (key == `FPS_KEY_ESC) begin
                pick_sel    <= pick_val;
                pick_active <= 1'b0;
              end else if (key == `FPS_KEY_RIGHT) begin
                pick_sel <= (pick_sel == pick_last) ? {PICK_W{1'b0}}
                            : pick_sel + {{(PICK_W-1){1'b0}}, 1'b1};
              end else if (key == `FPS_KEY_LEFT) begin
                pick_sel <= (pick_sel == {PICK_W{1'b0}}) ? pick_last
                            : pick_sel - {{(PICK_W-1){1'b0}}, 1'b1};
              end
            end else if (entry_active) begin
              if (key == `FPS_KEY_DIGIT) begin
                entry_buf  <= kdata;
                has_digits <= 1'b1;
              end else if (key == `FPS_KEY_ENTER) begin
                entry_active <= 1'b0;
                has_digits   <= 1'b0;
                if (has_digits && entry_buf >= lim_lo && entry_buf <= lim_hi) begin
                  param_val <= entry_buf;
                end else if (has_digits) begin
                  beep <= 1'b1;
                end
              end else if (key == `FPS_KEY_ESC) begin
                if (has_digits) begin
                  entry_buf  <= {VAL_W{1'b0}};
                  has_digits <= 1'b0;
                end else begin
                  entry_active <= 1'b0;
                end
              end
            end else begin
              case (key)
                `FPS_KEY_DIGIT: begin
                  if (ctrl[`FPS_CTRL_NUMERIC]) begin
                    entry_active <= 1'b1;
                    entry_buf    <= kdata;
                    has_digits   <= 1'b1;
                  end
                end
                `FPS_KEY_ENTER: begin
                  if (ctrl[`FPS_CTRL_PICKLIST]) begin
                    pick_active <= 1'b1;
                  end else if (ctrl[`FPS_CTRL_NUMERIC]) begin
                    entry_active <= 1'b1;
                    entry_buf    <= {VAL_W{1'b0}};
                    has_digits   <= 1'b0;
                  end
                end
                `FPS_KEY_ESC: begin
                  to_parent <= ctrl[`FPS_CTRL_HAS_PARENT];
                end
                `FPS_KEY_SHIFT: shift <= 1'b1;
                `FPS_KEY_RAMP: begin
                  if (sw_state != SW_IDLE) begin
                    beep <= 1'b1;
                  end
                end
                `FPS_KEY_SWITCH: begin
                  if (!sw_ready || sw_state != SW_IDLE) begin
                    beep <= 1'b1;
                  end else if (heater_on) begin
                    heater_on   <= 1'b0;
                    comp_enable <= 1'b0;
                    magnet_i    <= supply_setpoint;
                    sw_state    <= SW_COOL;
                  end else begin
                    supply_setpoint <= magnet_i;
                    ramp_zero       <= 1'b0;
                    sw_state        <= SW_RAMP;
                  end
                end
                default: begin
                  shift <= 1'b0;
                end
              endcase
            end
          end
          default: begin
            ctrl <= ctrl;
          end
        endcase
      end
    end
  end

  // cooling gain only applies during the cooling hold
  always @(posedge clk) begin
    if (!rst_b) begin
      loop_gain_add <= {VAL_W{1'b0}};
    end else begin
      loop_gain_add <= (sw_state == SW_COOL) ? cool_gain : {VAL_W{1'b0}};
    end
  end

endmodule // fps_sequencer

// ### core/fps_defs.vh
/*
  constants for the front panel entry and switch sequencer:
  register offsets, field positions, reset values and timing counts.
  assumes a 100 MHz system clock and an ahb-lite register bus.
*/
`ifndef FPS_DEFS_VH
`define FPS_DEFS_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define FPS_OFF_KEY      8'h00
`define FPS_OFF_CTRL     8'h04
`define FPS_OFF_ENTRY    8'h08
`define FPS_OFF_STATUS   8'h0C
`define FPS_OFF_SETPT    8'h10
`define FPS_OFF_LIMITS   8'h14
`define FPS_OFF_PICK     8'h18
`define FPS_OFF_HEATT    8'h1C
`define FPS_OFF_COOLT    8'h20
`define FPS_OFF_PSRATE   8'h24
`define FPS_OFF_MAGI     8'h28
`define FPS_OFF_GAIN     8'h2C
`define FPS_OFF_KNOB     8'h30

// ****************************************************************
// key codes written to the key register
// ****************************************************************
`define FPS_KEY_DIGIT    4'h1
`define FPS_KEY_ENTER    4'h2
`define FPS_KEY_ESC      4'h3
`define FPS_KEY_LEFT     4'h4
`define FPS_KEY_RIGHT    4'h5
`define FPS_KEY_SHIFT    4'h6
`define FPS_KEY_KNOB     4'h7
`define FPS_KEY_SWITCH   4'h8
`define FPS_KEY_RAMP     4'h9
`define FPS_KEY_OTHER    4'hA

// ****************************************************************
// ctrl register fields
// ****************************************************************
`define FPS_CTRL_ITEM_LO     0
`define FPS_CTRL_NUMERIC     2
`define FPS_CTRL_PICKLIST    3
`define FPS_CTRL_KNOB_OK     4
`define FPS_CTRL_SW_INST     5
`define FPS_CTRL_HCUR_SET    6
`define FPS_CTRL_HAS_PARENT  7

// item kinds for knob permission
`define FPS_ITEM_PLAIN   2'h0
`define FPS_ITEM_RATE    2'h1
`define FPS_ITEM_PSRATE  2'h2

// ****************************************************************
// reset values and limits
// ****************************************************************
`define FPS_HEAT_DEF     12'h014
`define FPS_HEAT_MIN     12'h005
`define FPS_HEAT_MAX     12'h078
`define FPS_COOL_DEF     12'h014
`define FPS_COOL_MIN     12'h005
`define FPS_COOL_MAX     12'hE10
`define FPS_PSRATE_DEF   16'h000A
`define FPS_GAIN_DEF     16'h0000

// ****************************************************************
// timing
// ****************************************************************
`define FPS_CLK_HZ       100000000
`define FPS_SEC_NS       1000000000
`define FPS_CLK_NS       10

`endif

// ### tb/fps_ramp_model.sv
/* far-side ramp engine model for the sequencer.
   assumes the setpoint is read on the sequencer clock. */
`timescale 1ns/1ps
module fps_ramp_model #(parameter DELAY = 12) (
  input  wire        clk,
  input  wire [15:0] supply_setpoint,
  output wire        ramp_done
);
  logic [15:0] last = 16'h0000; // setpoint seen one cycle ago
  int          cnt  = 0;        // cycles since the setpoint last moved
  // arrival is only reported after a whole ramp time, never at once
  // judged against the setpoint as it stands, so a new target is never met
  // by a stale arrival from the old one
  assign ramp_done = (last === supply_setpoint) && (cnt >= DELAY);
  always @(posedge clk) begin
    last <= supply_setpoint;
    cnt  <= (last !== supply_setpoint) ? 0 : cnt + 1;
  end
endmodule // fps_ramp_model

// ### tb/fps_sequencer_props.sv
/* assertions on the sequencer ports.
   assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
module fps_props #(
  parameter TICK_CYCLES = 100000000,
  parameter VAL_W       = 16,
  parameter PICK_W      = 3
) (
  input wire             clk,
  input wire             rst_b,
  input wire             hsel,
  input wire [31:0]      haddr,
  input wire [1:0]       htrans,
  input wire             hwrite,
  input wire [2:0]       hsize,
  input wire [31:0]      hwdata,
  input wire             hready,
  input wire             hreadyout,
  input wire             hresp,
  input wire [31:0]      hrdata,
  input wire             ramp_done,
  input wire [VAL_W-1:0] supply_setpoint,
  input wire             heater_on,
  input wire             beep,
  input wire             comp_enable,
  input wire [VAL_W-1:0] loop_gain_add,
  input wire             to_parent
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [31:0] on_cnt = 32'h0; // unbroken cycles with the heater on
  always @(posedge clk) on_cnt <= (!rst_b || !heater_on) ? 32'h0 : on_cnt + 32'h1;
  // the supply must not move while a freshly cooled switch settles
  sequence s_cool_hold;
    $stable(supply_setpoint) [*8];
  endsequence
  a_ready_high: assert property (hreadyout) else $error("ready low");
  a_resp_okay: assert property (!hresp) else $error("error response");
  a_beep_pulse: assert property (beep |=> !beep) else $error("beep too long");
  a_parent_pulse: assert property (to_parent |=> !to_parent) else $error("exit long");
  a_gain_cool: assert property (loop_gain_add != 0 |-> !heater_on) else $error("gain");
  a_comp_heat: assert property (comp_enable |-> heater_on) else $error("comp early");
  a_comp_delay: assert property ($rose(comp_enable) |-> on_cnt >= 5 * TICK_CYCLES)
    else $error("heated time short");
  a_cool_hold: assert property ($fell(heater_on) |=> s_cool_hold) else $error("moved");
  a_read_hold: assert property (!(hsel && htrans[1] && !hwrite && hready) |=> $stable(hrdata))
    else $error("read data moved");
endmodule // fps_props

bind fps_sequencer fps_props #(.TICK_CYCLES(TICK_CYCLES), .VAL_W(VAL_W), .PICK_W(PICK_W))
  u_props (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ramp_done(ramp_done),
    .supply_setpoint(supply_setpoint), .heater_on(heater_on), .beep(beep),
    .comp_enable(comp_enable), .loop_gain_add(loop_gain_add), .to_parent(to_parent));

// ### tb/tb_top.sv
/* self-checking bench for fps_sequencer.
   assumes the design is the only ahb-lite slave and a short tick. */
`timescale 1ns/1ps
`include "fps_defs.vh"
module tb_top;
  localparam TICK = 20; // short second keeps the holds near 100 cycles
  logic        clk = 0, rst_b = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp;
  logic        ramp_done, heater_on, beep, comp_enable, to_parent;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rv;
  logic [1:0]  htrans = 0;
  logic [15:0] supply_setpoint, loop_gain_add;
  int          n_errors = 0, total_checks = 0, cyc = 0, nb = 0, np = 0, i, b0;
  assign hready = hreadyout; // sole slave drives the bus ready
  always #5 clk = ~clk;
  fps_sequencer #(.TICK_CYCLES(TICK)) dut (.clk(clk), .rst_b(rst_b), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .ramp_done(ramp_done), .supply_setpoint(supply_setpoint), .heater_on(heater_on),
    .beep(beep), .comp_enable(comp_enable), .loop_gain_add(loop_gain_add),
    .to_parent(to_parent));
  fps_ramp_model u_ramp (.clk(clk), .supply_setpoint(supply_setpoint), .ramp_done(ramp_done));
  // count beeps and parent exits; cut a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (beep === 1'b1) nb <= nb + 1;
    if (to_parent === 1'b1) np <= np + 1;
    if (cyc == 40000) begin
      n_errors++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (n_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // one single transfer; read data is taken at the data-phase edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rv = hrdata;
  endtask
  task automatic key(input logic [3:0] k, input logic [15:0] p = 16'h0);
    bus(1, `FPS_OFF_KEY, {12'h0, k, p});
  endtask
  task automatic rd(input logic [7:0] a);
    bus(0, a, 32'h0);
  endtask
  task automatic t_reset();
    rd(`FPS_OFF_HEATT); chk(rv, 32'h14);
    rd(`FPS_OFF_COOLT); chk(rv, 32'h14);
    rd(`FPS_OFF_PSRATE); chk(rv, 32'hA);
    rd(8'h3C); chk(rv, 32'h0); // unmapped place reads zero
  endtask
  task automatic t_num();
    bus(1, `FPS_OFF_CTRL, 32'h84);
    bus(1, `FPS_OFF_LIMITS, 32'h0064000A);
    key(`FPS_KEY_DIGIT, 16'd50);
    rd(`FPS_OFF_STATUS); chk(rv[3], 1);
    rd(`FPS_OFF_SETPT); chk(rv, 0);
    key(`FPS_KEY_ENTER);
    rd(`FPS_OFF_SETPT); chk(rv, 50);
    b0 = nb;
    key(`FPS_KEY_DIGIT, 16'd200);
    key(`FPS_KEY_ENTER);
    rd(`FPS_OFF_SETPT); chk(rv, 50);
    chk(nb - b0, 1);
    key(`FPS_KEY_DIGIT, 16'd7);
    key(`FPS_KEY_ESC);
    rd(`FPS_OFF_STATUS); chk({rv[11], rv[3]}, 2'b01);
    key(`FPS_KEY_ESC);
    rd(`FPS_OFF_STATUS); chk(rv[3], 0);
    b0 = np;
    key(`FPS_KEY_ESC);
    rd(`FPS_OFF_SETPT); chk(rv, 50);
    chk(np - b0, 1);
    key(`FPS_KEY_ENTER);
    rd(`FPS_OFF_STATUS); chk(rv[3], 1);
    key(`FPS_KEY_ESC);
  endtask
  task automatic t_knob();
    bus(1, `FPS_OFF_CTRL, 32'h94);
    key(`FPS_KEY_SHIFT);
    key(`FPS_KEY_KNOB);
    rd(`FPS_OFF_STATUS); chk(rv[4], 1);
    bus(1, `FPS_OFF_KNOB, 32'h0);
    rd(`FPS_OFF_SETPT); chk(rv, 150);
    repeat (4200) @(posedge clk); // slow turn: coarse step no longer applies
    bus(1, `FPS_OFF_KNOB, 32'h1);
    rd(`FPS_OFF_SETPT); chk(rv, 140);
    key(`FPS_KEY_ESC);
    rd(`FPS_OFF_SETPT); chk(rv, 50);
    rd(`FPS_OFF_STATUS); chk(rv[4], 0);
    key(`FPS_KEY_SHIFT);
    key(`FPS_KEY_KNOB);
    bus(1, `FPS_OFF_KNOB, 32'h0);
    key(`FPS_KEY_ENTER);
    rd(`FPS_OFF_SETPT); chk(rv, 150);
  endtask
  task automatic t_pick();
    bus(1, `FPS_OFF_CTRL, 32'h88);
    bus(1, `FPS_OFF_PICK, 32'h200);
    key(`FPS_KEY_ENTER);
    rd(`FPS_OFF_STATUS); chk(rv[5], 1);
    key(`FPS_KEY_LEFT);
    rd(`FPS_OFF_PICK); chk(rv[2:0], 2);
    key(`FPS_KEY_RIGHT);
    key(`FPS_KEY_RIGHT);
    rd(`FPS_OFF_PICK); chk(rv[2:0], 1);
    key(`FPS_KEY_ENTER);
    rd(`FPS_OFF_PICK); chk(rv[5:3], 1);
    key(`FPS_KEY_ENTER);
    key(`FPS_KEY_RIGHT);
    key(`FPS_KEY_ESC);
    rd(`FPS_OFF_PICK); chk(rv[5:3], 1);
    rd(`FPS_OFF_STATUS); chk(rv[5], 0);
  endtask
  task automatic t_sw();
    bus(1, `FPS_OFF_CTRL, 32'h60);
    b0 = nb;
    key(`FPS_KEY_SWITCH);
    bus(1, `FPS_OFF_HEATT, 32'h4);
    rd(`FPS_OFF_HEATT); chk(rv, 32'h14);
    chk(nb - b0, 2);
    chk(heater_on, 0);
    bus(1, `FPS_OFF_HEATT, 32'h5);
    bus(1, `FPS_OFF_COOLT, 32'h5);
    bus(1, `FPS_OFF_GAIN, 32'h19);
    bus(1, `FPS_OFF_MAGI, 32'd30);
    key(`FPS_KEY_SWITCH);
    for (i = 0; i < 400 && heater_on !== 1'b1; i++) @(posedge clk);
    chk({ramp_done, supply_setpoint}, {1'b1, 16'd30});
    b0 = nb;
    key(`FPS_KEY_RAMP);
    rd(`FPS_OFF_STATUS); chk(nb - b0, 1);
    chk(comp_enable, 0);
    b0 = nb;
    bus(1, `FPS_OFF_CTRL, 32'h71);
    key(`FPS_KEY_SHIFT);
    key(`FPS_KEY_KNOB);
    rd(`FPS_OFF_STATUS); chk(nb - b0, 1);
    chk(rv[4], 0);
    for (i = 0; i < 400 && comp_enable !== 1'b1; i++) @(posedge clk);
    chk(comp_enable, 1);
    key(`FPS_KEY_SWITCH);
    rd(`FPS_OFF_STATUS); chk({heater_on, loop_gain_add}, 17'h19);
    chk(supply_setpoint, 30);
    for (i = 0; i < 400 && supply_setpoint !== 16'h0; i++) @(posedge clk);
    @(posedge clk); // gain output trails the switch state by one cycle
    chk({supply_setpoint, loop_gain_add}, 0);
    key(`FPS_KEY_SHIFT);
    key(`FPS_KEY_SWITCH);
    rd(`FPS_OFF_STATUS); chk({heater_on, supply_setpoint}, 17'h10000);
    rst_b <= 0;
    repeat (2) @(posedge clk);
    rst_b <= 1;
    @(posedge clk);
    chk(heater_on, 0);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1;
    @(posedge clk);
    t_reset();
    t_num();
    t_knob();
    t_pick();
    t_sw();
    stop_test();
  end
endmodule // tb_top
